// ---- hw/timer_pkg.sv ----
// Constants for the dual byte timer and PWM unit
// How it works
// - Mode is bit-length and output-mode bits taken together, giving modes 0 to 3.
// - Low prescaler source: 2-cycle ticks or events in modes 0/2, every cycle in 1/3.
// - In modes 0 and 2 the low half counts events when either external pin is selected, else 2-cycle ticks.
// - High source: 2-cycle ticks, every cycle, low match, or low PWM wrap by mode.
// - Prescaler divides by 1 when disabled, else by two to the power (code plus one).
// - Low half runs only with control bit 6 set, high half with bit 7.
// - Each prescaler clears when its half stops or when it emits a counter step.
// - Each counter steps per prescaler output and matches against its match buffer.
// - Low counter clears when stopped, and on match in modes 0 and 2 only.
// - High counter clears when stopped, and on match in modes 0, 2 and 3.
// - Low buffer follows its data while stopped, reloads at counter zero while running.
// - High buffer follows its data while stopped, reloads at counter zero while running.
// - Low output high while stopped, low while running with match data FFH.
// - High output high while stopped, low while running with match data FFH.
// - With output-mode 0 the low output toggles on each low match.
// - With output-mode 1 the low output falls on overflow and rises on match.
// - With output-mode 0 or bit-length 1 the high output toggles on each match.
// - With output-mode 1 and bit-length 0 high output falls on overflow, rises on match.
// - PWM period is 256 prescaled ticks; low phase is match value plus one ticks.
// - Cascaded period is high match plus one, times high prescale, times low period.
// - Each half requests an interrupt while its match flag and its enable bit are both set.
// - Match flag sets when counter reaches zero while running; software write clears it.
package timer_pkg;

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_CONTROL = 16'hfe18;
   localparam logic [15:0] IDX_PRESCALE = 16'hfe19;
   localparam logic [15:0] IDX_LOW_COUNT = 16'hfe1a;
   localparam logic [15:0] IDX_HIGH_COUNT = 16'hfe1b;
   localparam logic [15:0] IDX_LOW_DATA = 16'hfe1c;
   localparam logic [15:0] IDX_HIGH_DATA = 16'hfe1d;
   localparam logic [15:0] IDX_EXT_SELECT = 16'hfe1e;

   // Control register fields
   localparam int HIGH_RUN = 7;
   localparam int LOW_RUN = 6;
   localparam int BIT_LENGTH_SELECT = 5;
   localparam int OUTPUT_MODE_SELECT = 4;
   localparam int HIGH_MATCH_FLAG = 3;
   localparam int HIGH_IRQ_ENABLE = 2;
   localparam int LOW_MATCH_FLAG = 1;
   localparam int LOW_IRQ_ENABLE = 0;

   // Prescale select fields
   localparam int HIGH_PRESCALE_ENABLE = 7;
   localparam int HIGH_PRESCALE_CODE = 4;
   localparam int LOW_PRESCALE_ENABLE = 3;
   localparam int LOW_PRESCALE_CODE = 0;

   // External pin select fields
   localparam int EXT_SEL_A = 0;
   localparam int EXT_SEL_B = 1;

   // Reset value and all-ones match value
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] MATCH_ALL_ONES = 8'hff;

   // Mode codes, {bit_length_select, output_mode_select}
   localparam logic [1:0] MODE_TOGGLE = 2'h0;
   localparam logic [1:0] MODE_DUAL_PWM = 2'h1;
   localparam logic [1:0] MODE_CASCADE = 2'h2;
   localparam logic [1:0] MODE_CASCADE_PWM = 2'h3;

   function automatic logic [31:0] byte_addr(input logic [15:0] idx);
      byte_addr = {14'h0000, idx, 2'h0};
   endfunction

   // Divide ratio: 1, or 2 to the power (code + 1)
   function automatic logic [8:0] ratio(input logic en, input logic [2:0] code);
      ratio = en ? (9'h001 << ({1'b0, code} + 4'h1)) : 9'h001;
   endfunction

endpackage

// ---- hw/dual_byte_timer_pwm_unit.sv ----
// Dual byte timer/counter with toggle and PWM outputs behind an APB slave
`timescale 1ns/100ps
`default_nettype none
module dual_byte_timer_pwm_unit
   import timer_pkg::*;
(
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External event inputs
   input wire logic ext_input_a,
   input wire logic ext_input_b,
   // Timer outputs
   output logic low_output_pin,
   output logic high_output_pin,
   output logic irq_request
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] presel_q, presel_d;
   logic [7:0] low_data_q, low_data_d;
   logic [7:0] high_data_q, high_data_d;
   logic [1:0] ext_sel_q, ext_sel_d;
   logic [7:0] low_cnt_q, low_cnt_d;
   logic [7:0] high_cnt_q, high_cnt_d;
   logic [7:0] low_pre_q, low_pre_d;
   logic [7:0] high_pre_q, high_pre_d;
   logic [7:0] low_buf_q, low_buf_d;
   logic [7:0] high_buf_q, high_buf_d;
   logic div2_q, div2_d;
   logic ext_a_q, ext_a_d;
   logic ext_b_q, ext_b_d;
   logic low_out_q, low_out_d;
   logic high_out_q, high_out_d;
   logic irq_q, irq_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   logic access, wr_en, hit;
   logic [7:0] rd_byte;

   assign access = psel && penable && pready_q;
   assign wr_en = access && pwrite && hit;

   always_comb
   begin
      hit = 1'b1;
      rd_byte = RESET_BYTE;
      case (paddr)
         byte_addr(IDX_CONTROL): rd_byte = ctrl_q;
         byte_addr(IDX_PRESCALE): rd_byte = presel_q;
         byte_addr(IDX_LOW_COUNT): rd_byte = low_cnt_q;
         byte_addr(IDX_HIGH_COUNT): rd_byte = high_cnt_q;
         byte_addr(IDX_LOW_DATA): rd_byte = low_data_q;
         byte_addr(IDX_HIGH_DATA): rd_byte = high_data_q;
         byte_addr(IDX_EXT_SELECT): rd_byte = {6'h00, ext_sel_q};
         default: hit = 1'b0;
      endcase
   end

   // One wait state so that all bus outputs come from flops
   always_comb
   begin
      pready_d = psel && penable && !pready_q;
      pslverr_d = pready_d && !hit;
      prdata_d = prdata_q;
      if (pready_d && !pwrite)
      begin
         prdata_d = {24'h000000, rd_byte};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tick sources and mode
   logic [1:0] mode;
   logic low_run, high_run, low_pwm, high_pwm;
   logic tick2, ext_evt, low_src, high_src;
   logic [8:0] low_ratio, high_ratio;
   logic low_adv, high_adv, low_match_evt, high_match_evt;
   logic low_wrap, high_wrap, low_reach0, high_reach0;
   logic low_clr_on_match, high_clr_on_match;

   assign mode = {ctrl_q[BIT_LENGTH_SELECT], ctrl_q[OUTPUT_MODE_SELECT]};
   assign low_run = ctrl_q[LOW_RUN];
   assign high_run = ctrl_q[HIGH_RUN];
   assign low_pwm = ctrl_q[OUTPUT_MODE_SELECT];
   assign high_pwm = (mode == MODE_DUAL_PWM);
   assign tick2 = div2_q;
   // Inputs are synchronous; a rising edge is one event
   assign ext_evt = (ext_sel_q[EXT_SEL_A] && ext_input_a && !ext_a_q)
      || (ext_sel_q[EXT_SEL_B] && ext_input_b && !ext_b_q);

   always_comb
   begin
      // Pin select overrides the 2-cycle tick; PWM overrides pin select
      if (low_pwm)
      begin
         low_src = 1'b1;
      end
      else if (ext_sel_q != 2'h0)
      begin
         low_src = ext_evt;
      end
      else
      begin
         low_src = tick2;
      end
      case (mode)
         MODE_TOGGLE: high_src = tick2;
         MODE_DUAL_PWM: high_src = 1'b1;
         MODE_CASCADE: high_src = low_match_evt;
         MODE_CASCADE_PWM: high_src = low_wrap;
         default: high_src = 1'b0;
      endcase
   end

   assign low_ratio = ratio(presel_q[LOW_PRESCALE_ENABLE],
      presel_q[LOW_PRESCALE_CODE +: 3]);
   assign high_ratio = ratio(presel_q[HIGH_PRESCALE_ENABLE],
      presel_q[HIGH_PRESCALE_CODE +: 3]);
   assign low_adv = low_run && low_src && ({1'b0, low_pre_q} == low_ratio - 9'h001);
   assign high_adv = high_run && high_src && ({1'b0, high_pre_q} == high_ratio - 9'h001);
   assign low_match_evt = low_adv && (low_cnt_q == low_buf_q);
   assign high_match_evt = high_adv && (high_cnt_q == high_buf_q);
   assign low_wrap = low_adv && (low_cnt_q == MATCH_ALL_ONES);
   assign high_wrap = high_adv && (high_cnt_q == MATCH_ALL_ONES);
   assign low_clr_on_match = !low_pwm;
   assign high_clr_on_match = (mode != MODE_DUAL_PWM);
   // A match at data 0 also counts as reaching zero, else no flag ever sets
   assign low_reach0 = low_run && (low_cnt_d == 8'h00) && (low_cnt_q != 8'h00 || low_adv);
   assign high_reach0 = high_run && (high_cnt_d == 8'h00) && (high_cnt_q != 8'h00 || high_adv);

   ////////////////////////////////////////////////////////////////////////////
   // Timer next state
   always_comb
   begin
      div2_d = !div2_q;
      ext_a_d = ext_input_a;
      ext_b_d = ext_input_b;
      // Prescalers
      low_pre_d = low_pre_q;
      if (!low_run || low_adv)
      begin
         low_pre_d = 8'h00;
      end
      else if (low_src)
      begin
         low_pre_d = low_pre_q + 8'h01;
      end
      high_pre_d = high_pre_q;
      if (!high_run || high_adv)
      begin
         high_pre_d = 8'h00;
      end
      else if (high_src)
      begin
         high_pre_d = high_pre_q + 8'h01;
      end
      // Counters; the PWM wrap falls out of 8-bit arithmetic
      low_cnt_d = low_cnt_q;
      if (!low_run || (low_match_evt && low_clr_on_match))
      begin
         low_cnt_d = 8'h00;
      end
      else if (low_adv)
      begin
         low_cnt_d = low_cnt_q + 8'h01;
      end
      high_cnt_d = high_cnt_q;
      if (!high_run || (high_match_evt && high_clr_on_match))
      begin
         high_cnt_d = 8'h00;
      end
      else if (high_adv)
      begin
         high_cnt_d = high_cnt_q + 8'h01;
      end
   end

   // Buffers from counter next values, outputs from current match and wrap events
   always_comb
   begin
      low_buf_d = low_buf_q;
      if (!low_run || low_reach0)
      begin
         low_buf_d = low_data_q;
      end
      high_buf_d = high_buf_q;
      if (!high_run || high_reach0)
      begin
         high_buf_d = high_data_q;
      end
      low_out_d = low_out_q;
      if (!low_run)
      begin
         low_out_d = 1'b1;
      end
      else if (low_data_q == MATCH_ALL_ONES)
      begin
         low_out_d = 1'b0;
      end
      else if (low_pwm)
      begin
         if (low_wrap)
         begin
            low_out_d = 1'b0;
         end
         else if (low_match_evt)
         begin
            low_out_d = 1'b1;
         end
      end
      else if (low_match_evt)
      begin
         low_out_d = !low_out_q;
      end
      high_out_d = high_out_q;
      if (!high_run)
      begin
         high_out_d = 1'b1;
      end
      else if (high_data_q == MATCH_ALL_ONES)
      begin
         high_out_d = 1'b0;
      end
      else if (high_pwm)
      begin
         if (high_wrap)
         begin
            high_out_d = 1'b0;
         end
         else if (high_match_evt)
         begin
            high_out_d = 1'b1;
         end
      end
      else if (high_match_evt)
      begin
         high_out_d = !high_out_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software registers; hardware flag set beats a clearing write
   always_comb
   begin
      ctrl_d = ctrl_q;
      presel_d = presel_q;
      low_data_d = low_data_q;
      high_data_d = high_data_q;
      ext_sel_d = ext_sel_q;
      if (wr_en)
      begin
         case (paddr)
            byte_addr(IDX_CONTROL):
            begin
               ctrl_d = pwdata[7:0];
               // Flags can only be cleared by software
               ctrl_d[LOW_MATCH_FLAG] = pwdata[LOW_MATCH_FLAG] && ctrl_q[LOW_MATCH_FLAG];
               ctrl_d[HIGH_MATCH_FLAG] = pwdata[HIGH_MATCH_FLAG] && ctrl_q[HIGH_MATCH_FLAG];
            end
            byte_addr(IDX_PRESCALE): presel_d = pwdata[7:0];
            byte_addr(IDX_LOW_DATA): low_data_d = pwdata[7:0];
            byte_addr(IDX_HIGH_DATA): high_data_d = pwdata[7:0];
            byte_addr(IDX_EXT_SELECT): ext_sel_d = pwdata[1:0];
            default: ctrl_d = ctrl_q;
         endcase
      end
      if (low_reach0)
      begin
         ctrl_d[LOW_MATCH_FLAG] = 1'b1;
      end
      if (high_reach0)
      begin
         ctrl_d[HIGH_MATCH_FLAG] = 1'b1;
      end
      irq_d = (ctrl_q[LOW_MATCH_FLAG] && ctrl_q[LOW_IRQ_ENABLE])
         || (ctrl_q[HIGH_MATCH_FLAG] && ctrl_q[HIGH_IRQ_ENABLE]);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         ctrl_q <= RESET_BYTE;
         presel_q <= RESET_BYTE;
         low_data_q <= RESET_BYTE;
         high_data_q <= RESET_BYTE;
         ext_sel_q <= 2'h0;
         low_cnt_q <= RESET_BYTE;
         high_cnt_q <= RESET_BYTE;
         low_pre_q <= RESET_BYTE;
         high_pre_q <= RESET_BYTE;
         low_buf_q <= RESET_BYTE;
         high_buf_q <= RESET_BYTE;
         div2_q <= 1'b0;
         ext_a_q <= 1'b0;
         ext_b_q <= 1'b0;
         low_out_q <= 1'b1;
         high_out_q <= 1'b1;
         irq_q <= 1'b0;
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else if (clk_en)
      begin
         ctrl_q <= ctrl_d;
         presel_q <= presel_d;
         low_data_q <= low_data_d;
         high_data_q <= high_data_d;
         ext_sel_q <= ext_sel_d;
         low_cnt_q <= low_cnt_d;
         high_cnt_q <= high_cnt_d;
         low_pre_q <= low_pre_d;
         high_pre_q <= high_pre_d;
         low_buf_q <= low_buf_d;
         high_buf_q <= high_buf_d;
         div2_q <= div2_d;
         ext_a_q <= ext_a_d;
         ext_b_q <= ext_b_d;
         low_out_q <= low_out_d;
         high_out_q <= high_out_d;
         irq_q <= irq_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign low_output_pin = low_out_q;
   assign high_output_pin = high_out_q;
   assign irq_request = irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   sequence low_stopped;
      clk_en && !ctrl_q[LOW_RUN];
   endsequence
   sequence high_stopped;
      clk_en && !ctrl_q[HIGH_RUN];
   endsequence

   low_stop_out_a: assert property (low_stopped |=> low_out_q)
      else $error("low output not high while stopped");
   high_stop_out_a: assert property (high_stopped |=> high_out_q)
      else $error("high output not high while stopped");
   low_stop_clear_a: assert property (low_stopped |=> low_cnt_q == 8'h00)
      else $error("low counter not cleared while stopped");
   low_buf_follow_a: assert property (low_stopped |=> low_buf_q == $past(low_data_q))
      else $error("low buffer not following data");
   high_match_clear_a: assert property (clk_en && high_match_evt
      && mode != MODE_DUAL_PWM |=> high_cnt_q == 8'h00)
      else $error("high counter not cleared on match");
   low_toggle_out_a: assert property (clk_en && low_run && !low_pwm && low_match_evt
      && low_data_q != MATCH_ALL_ONES |=> low_out_q != $past(low_out_q))
      else $error("low output failed to toggle");
   low_pwm_wrap_a: assert property (clk_en && low_run && low_pwm && low_wrap
      && low_data_q != MATCH_ALL_ONES |=> !low_out_q)
      else $error("low PWM not low after wrap");
   prescale_bound_a: assert property ({1'b0, low_pre_q} < low_ratio
      || $past(presel_q) != presel_q)
      else $error("low prescaler beyond ratio");
   low_flag_set_a: assert property (clk_en && low_reach0 |=> ctrl_q[LOW_MATCH_FLAG])
      else $error("low match flag not set");
   irq_follow_a: assert property (clk_en && ctrl_q[HIGH_MATCH_FLAG] && ctrl_q[HIGH_IRQ_ENABLE]
      |=> irq_request)
      else $error("interrupt not raised");

endmodule
`default_nettype wire

// ---- sim/dual_byte_timer_pwm_unit_tb.sv ----
// Self-checking testbench for the dual byte timer and PWM unit
`timescale 1ns/100ps
`default_nettype none
module dual_byte_timer_pwm_unit_tb
   import timer_pkg::*;
;
   typedef struct packed {logic [15:0] idx; logic [7:0] wd; logic [7:0] exp; logic err;} row_t;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ext_input_a = 1'b0;
   logic ext_input_b = 1'b0;
   logic low_output_pin;
   logic high_output_pin;
   logic irq_request;
   int num_errors = 0;
   int comparisons = 0;
   // Ordinary cases: write, then read back; flags refuse a written 1
   row_t rows [8] = '{
      '{IDX_CONTROL, 8'h0f, 8'h05, 1'b0},
      '{IDX_PRESCALE, 8'ha5, 8'ha5, 1'b0},
      '{IDX_LOW_COUNT, 8'h33, 8'h00, 1'b0},
      '{IDX_HIGH_COUNT, 8'h44, 8'h00, 1'b0},
      '{IDX_LOW_DATA, 8'h5a, 8'h5a, 1'b0},
      '{IDX_HIGH_DATA, 8'hc3, 8'hc3, 1'b0},
      '{IDX_EXT_SELECT, 8'h03, 8'h03, 1'b0},
      '{16'hfe1f, 8'h77, 8'h00, 1'b1}};

   always #10 ref_clk = ~ref_clk;

   dual_byte_timer_pwm_unit dut_u (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .ext_input_a(ext_input_a),
      .ext_input_b(ext_input_b),
      .low_output_pin(low_output_pin),
      .high_output_pin(high_output_pin),
      .irq_request(irq_request)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [31:0] ad(input logic [15:0] idx);
      ad = {14'h0000, idx, 2'h0};
   endfunction

   function automatic logic pin(input bit hi);
      pin = hi ? high_output_pin : low_output_pin;
   endfunction

   // One idle edge first, so back-to-back calls never drive twice in a step
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad(idx);
      pwdata <= {24'h000000, wd};
      @(posedge ref_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         chk(1'b0, 1'b1, "bus answer");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, idx, d, r, e);
   endtask

   task automatic rdc(input logic [15:0] idx, input logic [7:0] exp, input logic err_exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, idx, 8'h00, r, e);
      chk(r, {24'h000000, exp}, "read data");
      chk(e, err_exp, "slave error");
   endtask

   task automatic setup(input logic [7:0] ctl, input logic [7:0] pre,
                        input logic [7:0] ld, input logic [7:0] hd);
      wr(IDX_CONTROL, 8'h00);
      wr(IDX_PRESCALE, pre);
      wr(IDX_LOW_DATA, ld);
      wr(IDX_HIGH_DATA, hd);
      wr(IDX_CONTROL, ctl);
   endtask

   // Skips any partial phase, then times one whole phase at level v
   task automatic lvl(input bit hi, input logic v, input int exp);
      int n;
      n = 0;
      while (pin(hi) === v && n < 3000)
      begin
         @(posedge ref_clk);
         n++;
      end
      n = 0;
      while (pin(hi) !== v && n < 3000)
      begin
         @(posedge ref_clk);
         n++;
      end
      n = 0;
      while (pin(hi) === v && n < 3000)
      begin
         @(posedge ref_clk);
         n++;
      end
      chk(n, exp, "phase length");
   endtask

   task automatic pulse(input bit b);
      @(posedge ref_clk);
      if (b)
         ext_input_b <= 1'b1;
      else
         ext_input_a <= 1'b1;
      repeat (3) @(posedge ref_clk);
      ext_input_a <= 1'b0;
      ext_input_b <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] r1;
      logic [31:0] r2;
      logic e1;
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      foreach (rows[i]) rdc(rows[i].idx, 8'h00, rows[i].err);
      chk({low_output_pin, high_output_pin, irq_request}, 3'b110, "reset pins");
      foreach (rows[i])
      begin
         wr(rows[i].idx, rows[i].wd);
         rdc(rows[i].idx, rows[i].exp, rows[i].err);
      end
      foreach (rows[i]) wr(rows[i].idx, 8'h00);
      $display("register test done");
      // Mode 0, undivided, both interrupts enabled
      setup(8'hc5, 8'h00, 8'h02, 8'h04);
      lvl(1'b0, 1'b0, 6);
      lvl(1'b1, 1'b0, 10);
      rdc(IDX_CONTROL, 8'hcf, 1'b0);
      chk(irq_request, 1'b1, "irq raised");
      wr(IDX_CONTROL, 8'h00);
      // A flag set in the stopping cycle beats the clear, so clear once more
      wr(IDX_CONTROL, 8'h00);
      repeat (4) @(posedge ref_clk);
      chk({low_output_pin, high_output_pin, irq_request}, 3'b110, "stopped");
      rdc(IDX_LOW_COUNT, 8'h00, 1'b0);
      rdc(IDX_HIGH_COUNT, 8'h00, 1'b0);
      $display("mode 0 test done");
      // Mode 0 with prescalers, interrupts masked
      setup(8'hc0, 8'h98, 8'h02, 8'h01);
      lvl(1'b0, 1'b0, 12);
      lvl(1'b1, 1'b0, 16);
      rdc(IDX_CONTROL, 8'hca, 1'b0);
      chk(irq_request, 1'b0, "irq masked");
      $display("prescale test done");
      // Mode 1, two PWMs
      setup(8'hd0, 8'h80, 8'h03, 8'h07);
      lvl(1'b0, 1'b0, 4);
      lvl(1'b0, 1'b1, 252);
      lvl(1'b1, 1'b0, 16);
      $display("mode 1 test done");
      // Mode 2, cascade on low match
      setup(8'he0, 8'h00, 8'h01, 8'h02);
      lvl(1'b0, 1'b0, 4);
      lvl(1'b1, 1'b0, 12);
      $display("mode 2 test done");
      // Mode 3, low PWM clocks the high half once per period
      setup(8'hf0, 8'h00, 8'h03, 8'h01);
      lvl(1'b0, 1'b0, 4);
      lvl(1'b1, 1'b0, 512);
      $display("mode 3 test done");
      // Event counting on either pin, high half left stopped
      wr(IDX_EXT_SELECT, 8'h01);
      setup(8'h40, 8'h00, 8'h01, 8'h00);
      pulse(1'b0);
      repeat (20) @(posedge ref_clk);
      rdc(IDX_LOW_COUNT, 8'h01, 1'b0);
      chk({low_output_pin, high_output_pin}, 2'b11, "one event");
      pulse(1'b0);
      chk(low_output_pin, 1'b0, "two events");
      wr(IDX_EXT_SELECT, 8'h02);
      pulse(1'b1);
      pulse(1'b1);
      chk(low_output_pin, 1'b1, "events on b");
      rdc(IDX_HIGH_COUNT, 8'h00, 1'b0);
      wr(IDX_EXT_SELECT, 8'h00);
      $display("event test done");
      // Match data FFH pins the output low while running
      setup(8'h40, 8'h00, 8'hff, 8'h00);
      repeat (4) @(posedge ref_clk);
      chk(low_output_pin, 1'b0, "ffh low");
      wr(IDX_CONTROL, 8'h00);
      repeat (4) @(posedge ref_clk);
      chk(low_output_pin, 1'b1, "ffh stopped");
      $display("ffh test done");
      // Clock enable low freezes the counter; only running edges count
      setup(8'h40, 8'h00, 8'hff, 8'h00);
      apb(1'b0, IDX_LOW_COUNT, 8'h00, r1, e1);
      clk_en <= 1'b0;
      repeat (10) @(posedge ref_clk);
      clk_en <= 1'b1;
      apb(1'b0, IDX_LOW_COUNT, 8'h00, r2, e1);
      chk(r2, r1 + 32'h00000002, "frozen count");
      $display("clock enable test done");
      // Reset in mid-run returns pins, registers and counters to idle
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      chk({low_output_pin, high_output_pin, irq_request}, 3'b110, "mid-run reset");
      rdc(IDX_CONTROL, 8'h00, 1'b0);
      rdc(IDX_LOW_COUNT, 8'h00, 1'b0);
      $display("reset test done");
      test_done;
   end

   initial
   begin
      repeat (60000) @(posedge ref_clk);
      num_errors++;
      $display("ERROR %0t: watchdog expired", $time);
      test_done;
   end

endmodule
`default_nettype wire
